// *** design/sao_defines.vh ***
// Purpose: Shared constants for the stereo serial output block.
// Assumes: 125 MHz system clock, word rate clock between 24 and 54 kHz.
// Notes: Definitions only.
`ifndef SAO_DEFINES_VH
`define SAO_DEFINES_VH
`define SAO_SAMPLE_W 24
`define SAO_ACC_W 40
`define SAO_MAX_POS 24'h7fffff
`define SAO_MAX_NEG 24'h800000
`define SAO_SLOTS_LONG 6'h20
`define SAO_SLOTS_SHORT 6'h18
`define SAO_BITS_LONG 7'h40
`define SAO_BITS_SHORT 7'h30
`define SAO_HPF_SHIFT 5'h0c
`define SAO_COMP_SHIFT 5'h04
`define SAO_PERIOD_W 16
`define SAO_PERIOD_MIN 16'h0900
`define SAO_PERIOD_MAX 16'h1460
`define SAO_LOOP_SHIFT 4'h3
`endif

// *** design/sao_sample_filter.v ***
// Purpose: High-pass, droop compensation and saturation of one sample.
// Assumes: One sample per stb pulse, alternating channels by chan.
// Notes: Result registered one cycle after stb.
`include "sao_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module sao_sample_filter #(
  parameter W = `SAO_SAMPLE_W
) (
  input wire sys_clk,
  input wire rstn,
  input wire stb,
  input wire chan,
  input wire signed [W-1:0] din,
  output reg signed [W-1:0] dout_r,
  output reg done_r
);
  // ****************************************
  // Saturation helper
  // ****************************************
  function [W-1:0] sat;
    input signed [`SAO_ACC_W-1:0] v;
    begin
      if (v > $signed({{(`SAO_ACC_W-W){1'b0}}, `SAO_MAX_POS}))
        sat = `SAO_MAX_POS;
      else if (v < $signed({{(`SAO_ACC_W-W){1'b1}}, `SAO_MAX_NEG}))
        sat = `SAO_MAX_NEG;
      else
        sat = v[W-1:0];
    end
  endfunction
  reg signed [`SAO_ACC_W-1:0] dc_r [0:1];
  reg signed [`SAO_ACC_W-1:0] prev_r [0:1];
  reg signed [`SAO_ACC_W-1:0] x;
  reg signed [`SAO_ACC_W-1:0] hp;
  reg signed [`SAO_ACC_W-1:0] comp;
  always @* begin
    x = {{(`SAO_ACC_W-W){din[W-1]}}, din};
    hp = x - (dc_r[chan] >>> `SAO_HPF_SHIFT);
    comp = hp + ((hp - prev_r[chan]) >>> `SAO_COMP_SHIFT);
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dc_r[0] <= {`SAO_ACC_W{1'b0}};
      dc_r[1] <= {`SAO_ACC_W{1'b0}};
      prev_r[0] <= {`SAO_ACC_W{1'b0}};
      prev_r[1] <= {`SAO_ACC_W{1'b0}};
      dout_r <= {W{1'b0}};
      done_r <= 1'b0;
    end else begin
      done_r <= stb;
      if (stb) begin
        // The integrator tracks the offset at a tiny rate, giving a low corner.
        dc_r[chan] <= dc_r[chan] + hp;
        prev_r[chan] <= hp;
        dout_r <= sat(comp);
      end
    end
  end
endmodule
`default_nettype wire

// *** design/sao_bit_timer.v ***
// Purpose: Locks to word rate clock edges and issues bit slot enables.
// Assumes: Word rate clock already synchronised.
// Notes: A digital loop stands in for the analog phase-locked loop.
`include "sao_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module sao_bit_timer #(
  parameter PW = `SAO_PERIOD_W
) (
  input wire sys_clk,
  input wire rstn,
  input wire wrc_rise,
  input wire [6:0] bits_per_frame,
  output reg bit_en_r,
  output reg [6:0] bit_idx_r,
  output reg locked_r
);
  reg [PW-1:0] cnt_r;
  reg [PW-1:0] period_r;
  reg [PW+6:0] acc_r;
  reg [PW+6:0] acc_nxt;
  wire [PW-1:0] meas;
  wire ok;
  wire [PW:0] diff;
  wire signed [PW:0] step;
  assign meas = cnt_r + 1'b1;
  assign ok = (meas >= `SAO_PERIOD_MIN) && (meas <= `SAO_PERIOD_MAX);
  // The error is signed, so a word clock that runs slightly fast pulls the period down.
  assign diff = {1'b0, meas} - {1'b0, period_r};
  assign step = $signed(diff) >>> `SAO_LOOP_SHIFT;
  always @* begin
    acc_nxt = acc_r + {{PW{1'b0}}, bits_per_frame};
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      // Start saturated so the first rise after reset never counts as a period.
      cnt_r <= {PW{1'b1}};
      period_r <= `SAO_PERIOD_MIN;
      acc_r <= {(PW+7){1'b0}};
      bit_en_r <= 1'b0;
      bit_idx_r <= 7'h00;
      locked_r <= 1'b0;
    end else begin
      bit_en_r <= 1'b0;
      if (wrc_rise) begin
        cnt_r <= {PW{1'b0}};
        if (ok && locked_r)
          period_r <= period_r + step[PW-1:0];
        else if (ok)
          period_r <= meas;
        locked_r <= ok;
        acc_r <= {(PW+7){1'b0}};
        bit_idx_r <= 7'h00;
        bit_en_r <= ok;
      end else begin
        if (cnt_r != {PW{1'b1}})
          cnt_r <= cnt_r + 1'b1;
        // A fractional accumulator spreads bit slots evenly over the period.
        if (acc_nxt >= {7'h00, period_r}) begin
          acc_r <= acc_nxt - {7'h00, period_r};
          if (bit_idx_r < bits_per_frame - 7'h01) begin
            bit_idx_r <= bit_idx_r + 7'h01;
            bit_en_r <= locked_r;
          end
        end else begin
          acc_r <= acc_nxt;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** design/sao_serial_out.v ***
// Purpose: Stereo 24-bit serial output stage timed by the word rate clock.
// Assumes: Samples arrive with a one-cycle strobe from the converter core.
// Notes: Output is zero until the timing loop has seen a sane period.
//
// What this block does
// - Clip samples to 7fffff and 800000.
// - Send two's complement samples MSB first.
// - Frame select low gives 32-bit frames.
// - Frame select high gives 24-bit frames.
// - Sample period runs between word clock rising edges.
// - Left sample starts at the word clock rising edge.
// - Right sample starts half a period later, regardless of duty.
// - Data changes on bit clock rises aligned to word clock rises.
// - 32-bit mode bit clock is 64 times the sample rate.
// - 24-bit mode bit clock is 48 times the sample rate.
// - Single-pole high-pass filter removes DC.
// - Timing comes from a loop locked to word clock rises.
// - Pre-compensate droop of an external 80 kHz filter.
`include "sao_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module sao_serial_out #(
  parameter W = `SAO_SAMPLE_W
) (
  input wire sys_clk,
  input wire rstn,
  input wire word_rate_clock,
  input wire frame_short,
  input wire sample_stb,
  input wire sample_right,
  input wire [W-1:0] sample_data,
  output reg serial_data_r,
  output wire sample_ack
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  reg wrc_s1_r;
  reg wrc_s2_r;
  reg wrc_d_r;
  reg fs_s1_r;
  reg fs_s2_r;
  reg mode_r;
  wire wrc_rise;
  always @(posedge sys_clk) begin
    // The synchronisers run through reset, so a high word clock at release is no false edge.
    wrc_s1_r <= word_rate_clock;
    wrc_s2_r <= wrc_s1_r;
    wrc_d_r <= wrc_s2_r;
    fs_s1_r <= frame_short;
    fs_s2_r <= fs_s1_r;
    if (!rstn) begin
      mode_r <= 1'b0;
    end else begin
      // Mode only changes at a frame boundary so no frame is torn.
      if (wrc_rise)
        mode_r <= fs_s2_r;
    end
  end
  assign wrc_rise = wrc_s2_r & ~wrc_d_r;

  // ****************************************
  // Frame geometry
  // ****************************************
  wire [5:0] slots;
  wire [6:0] bits;
  assign slots = mode_r ? `SAO_SLOTS_SHORT : `SAO_SLOTS_LONG;
  assign bits = mode_r ? `SAO_BITS_SHORT : `SAO_BITS_LONG;

  wire bit_en;
  wire [6:0] bit_idx;
  wire locked;
  sao_bit_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wrc_rise(wrc_rise),
    .bits_per_frame(bits),
    .bit_en_r(bit_en),
    .bit_idx_r(bit_idx),
    .locked_r(locked)
  );

  // ****************************************
  // Filtering
  // ****************************************
  wire [W-1:0] filt;
  wire filt_done;
  reg filt_chan_r;
  sao_sample_filter #(.W(W)) u_filter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .stb(sample_stb),
    .chan(sample_right),
    .din(sample_data),
    .dout_r(filt),
    .done_r(filt_done)
  );
  assign sample_ack = sample_stb;

  // ****************************************
  // Sample holding and shifting
  // ****************************************
  reg [W-1:0] left_r;
  reg [W-1:0] right_r;
  reg [W-1:0] shift_r;
  wire [5:0] slot_in_half;
  wire second_half;
  assign second_half = ({1'b0, bit_idx} >= {2'b00, slots});
  assign slot_in_half = second_half ? (bit_idx[5:0] - slots) : bit_idx[5:0];
  always @(posedge sys_clk) begin
    if (!rstn) begin
      filt_chan_r <= 1'b0;
      left_r <= {W{1'b0}};
      right_r <= {W{1'b0}};
      shift_r <= {W{1'b0}};
      serial_data_r <= 1'b0;
    end else begin
      filt_chan_r <= sample_right;
      if (filt_done && !filt_chan_r)
        left_r <= filt;
      if (filt_done && filt_chan_r)
        right_r <= filt;
      if (bit_en) begin
        if (slot_in_half == 6'h00) begin
          // load left at rise, right at half period
          shift_r <= {(second_half ? right_r[W-2:0] : left_r[W-2:0]), 1'b0};
          serial_data_r <= second_half ? right_r[W-1] : left_r[W-1];
        end else if (slot_in_half < W[5:0]) begin
          serial_data_r <= shift_r[W-1];
          shift_r <= {shift_r[W-2:0], 1'b0};
        end else begin
          serial_data_r <= 1'b0;
        end
      end else if (!locked) begin
        serial_data_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/sao_serial_out_checker.sv ***
// Purpose: Port checks for the serial output stage.
// Assumes: The word clock rate stays fixed while 32-bit frames run.
// Notes: Windows keep margin because the word clock is async.
`timescale 1ns/1ns
`default_nettype none
// ***
// Checker
// ***
module sao_serial_out_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic word_rate_clock,
  input wire logic frame_short,
  input wire logic sample_stb,
  input wire logic sample_ack,
  input wire logic serial_data_r
);
  localparam int MIN_GAP = 30;
  logic [2:0] s_r, stab_r;
  logic [15:0] cnt_r, per_r, gap_r;
  logic short_r, last_r;
  logic [1:0] fs_r;
  wire rise = s_r[1] & ~s_r[2];
  wire z = !short_r && stab_r == 3'h7;
  always @(posedge sys_clk) begin
    s_r <= {s_r[1:0], word_rate_clock};
    fs_r <= {fs_r[0], frame_short};
    last_r <= serial_data_r;
    gap_r <= (serial_data_r != last_r) ? 16'h0 : gap_r + (gap_r != 16'hffff);
    cnt_r <= rise ? 16'h0 : cnt_r + 16'h1;
    if (rise) begin
      per_r <= cnt_r + 16'h1;
      short_r <= fs_r[1];
      stab_r <= stab_r + (stab_r != 3'h7);
    end
    if (!rstn) begin
      stab_r <= 3'h0;
      gap_r <= 16'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ack_on_a: assert property (sample_stb |-> sample_ack) else $error("no ack");
  ack_off_a: assert property (!sample_stb |-> !sample_ack) else $error("stray ack");
  reset_quiet_a: assert property (disable iff (1'h0) !rstn |=> !serial_data_r)
    else $error("data in reset");
  start_quiet_a: assert property ($rose(rstn) |-> !serial_data_r [*8])
    else $error("data after reset");
  unlocked_quiet_a: assert property (stab_r < 3'h2 |-> !serial_data_r)
    else $error("data before lock");
  slot_gap_a: assert property (serial_data_r != last_r |-> gap_r >= MIN_GAP)
    else $error("slot too short");
  // Pad slots start two cycles after the slot edge, so the windows skip four.
  zero_left_a: assert property (
    z && cnt_r > (per_r * 3 >> 3) + 4 && cnt_r < per_r >> 1 |-> !serial_data_r)
    else $error("left pad set");
  zero_right_a: assert property (
    z && cnt_r > (per_r * 7 >> 3) + 4 |-> !serial_data_r) else $error("right pad set");
  cover property (rise && z);
  cover property (rise && short_r && stab_r == 3'h7);
  cover property (sample_stb ##1 sample_stb);
endmodule
bind sao_serial_out sao_serial_out_checker u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .word_rate_clock(word_rate_clock), .frame_short(frame_short), .sample_stb(sample_stb),
  .sample_ack(sample_ack), .serial_data_r(serial_data_r));
`default_nettype wire

// *** bench/sao_wclk_model.sv ***
// Purpose: Receiver side that makes the word clock.
// Assumes: Period and high time given in ns.
// Notes: A 3 ns start offset keeps it off the system clock phase.
`timescale 1ns/1ns
`default_nettype none
// ***
// Word clock source
// ***
module sao_wclk_model (
  input wire logic run,
  input var int period_ns,
  input var int high_ns,
  output logic word_rate_clock
);
  initial begin
    word_rate_clock = 1'h0;
    #3;
    forever begin
      wait (run);
      word_rate_clock = 1'h1;
      #(high_ns);
      word_rate_clock = 1'h0;
      #(period_ns - high_ns);
    end
  end
endmodule
`default_nettype wire

// *** bench/sao_serial_out_tb.sv ***
// Purpose: Bench for the serial output stage.
// Assumes: Filter state is zero, so a full-scale step clips.
// Notes: Bits are sampled mid-slot to ride out the async word clock.
`timescale 1ns/1ns
`default_nettype none
// ***
// Bench
// ***
module sao_serial_out_tb;
  logic sys_clk, rstn, frame_short, sample_stb, sample_right, run;
  logic [23:0] sample_data;
  wire word_rate_clock, serial_data_r, sample_ack;
  int period_ns, high_ns, error_cnt, num_checks, cyc;
  sao_serial_out DUT (.sys_clk(sys_clk), .rstn(rstn), .word_rate_clock(word_rate_clock),
    .frame_short(frame_short), .sample_stb(sample_stb), .sample_right(sample_right),
    .sample_data(sample_data), .serial_data_r(serial_data_r), .sample_ack(sample_ack));
  sao_wclk_model PEER (.run(run), .period_ns(period_ns), .high_ns(high_ns),
    .word_rate_clock(word_rate_clock));
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Late in a frame, so both halves of the next frame carry the new pair.
  task feed(input logic [23:0] l, input logic [23:0] r);
    @(posedge word_rate_clock);
    repeat (period_ns * 3 / 32) tick;
    sample_stb = 1'h1;
    sample_right = 1'h0;
    sample_data = l;
    tick;
    sample_right = 1'h1;
    sample_data = r;
    tick;
    sample_stb = 1'h0;
  endtask
  task cap(input int n, output logic [63:0] v);
    int s;
    s = period_ns / 8 / n;
    v = 64'h0;
    @(posedge word_rate_clock);
    repeat (5 + s / 2) @(negedge sys_clk);
    for (int k = 0; k < n; k++) begin
      v = {v[62:0], serial_data_r};
      repeat (s) @(negedge sys_clk);
    end
  endtask
  task long_frame;
    logic [63:0] v;
    repeat (10) @(posedge word_rate_clock);
    feed(24'h7fffff, 24'h800000);
    cap(64, v);
    chk(v, 64'h7fffff00_80000000);
  endtask
  task short_pulse_frame;
    logic [63:0] v;
    @(posedge word_rate_clock);
    tick;
    frame_short = 1'h1;
    period_ns = 23040;
    high_ns = 200;
    repeat (12) @(posedge word_rate_clock);
    feed(24'h800000, 24'h7fffff);
    cap(48, v);
    chk(v, 64'h800000_7fffff);
  endtask
  initial begin
    rstn = 1'h0;
    run = 1'h0;
    frame_short = 1'h0;
    sample_stb = 1'h0;
    sample_right = 1'h0;
    sample_data = 24'h0;
    period_ns = 20480;
    high_ns = 10240;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) tick;
    rstn = 1'h1;
    run = 1'h1;
    long_frame;
    short_pulse_frame;
    report_and_stop;
  end
  // The frames need about 80k cycles, so this ceiling only cuts a hang.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      report_and_stop;
    end
  end
endmodule
`default_nettype wire
